// ===== design/mon_pkg.sv
package mon_pkg;
  localparam logic [8:0] BIT_CYC_EXT = 9'h100;
  localparam logic [8:0] BIT_CYC_INT = 9'h0ce;
  localparam logic [3:0] GAP_BITS = 4'h2;
  localparam logic [3:0] FRAME_BITS = 4'ha;
  localparam logic [3:0] CMD_DELAY_BITS = 4'hb;
  localparam logic [2:0] SEC_LAST = 3'h7;
  localparam logic [7:0] OPC_READ = 8'h01;
  localparam logic [7:0] OPC_WRITE = 8'h02;
  localparam logic [7:0] OPC_INDEXED_READ_CMD = 8'h03;
  localparam logic [7:0] OPC_INDEXED_WRITE_CMD = 8'h19;
  localparam logic [7:0] OPC_STACK_POINTER_READ_CMD = 8'h0c;
  localparam logic [7:0] OPC_RUN = 8'h04;
  localparam logic [7:0] USER_VEC_PAGE = 8'hff;
  localparam logic [7:0] MON_VEC_PAGE = 8'hfe;
  localparam logic [7:0] VEC_LOW_FIRST = 8'hfc;
  localparam logic [15:0] SEC_FLAG_ADDR = 16'h0080;
  localparam logic [7:0] SEC_FLAG_VAL = 8'h40;
  localparam logic [7:0] BLANK_BYTE = 8'hff;
  localparam logic [7:0] INVALID_BYTE = 8'h00;
  localparam logic [15:0] SP_RET_OFS = 16'h0001;
  localparam logic [2:0] STK_IDX_HI = 3'h1;
  localparam logic [2:0] STK_CCR = 3'h2;
  localparam logic [2:0] STK_ACC = 3'h3;
  localparam logic [2:0] STK_IDX_LO = 3'h4;
  localparam logic [2:0] STK_PC_HI = 3'h5;
  localparam logic [2:0] STK_PC_LO = 3'h6;
endpackage : mon_pkg

// ===== design/mon_port.sv
`timescale 1ns/1ps
// Contract
// - Monitor mode maps vectors to page FE
// - Blank-vector monitor left only by power-on
// - NRZ framing, one shared bit rate
// - Break is ten low bit times
// - On break release two bits, echo break
// - External oscillator bit time 256 cycles
// - Internal oscillator bit time 206 cycles
// - Echo every received byte
// - Wait 11 bits; break cancels command
// - Two bit gap before echo, read data
// - Read data follows last echo
// - Indexed write opcode 19 at last+1
// - Stack read 0C returns SP+1, high first
// - Indexed commands step through 64K
// - Run pulls index high, returns
// - Stacked registers at SP+1 through SP+6
// - After power-on compare eight security bytes
// - Match unlocks flash until power-on
// - Mismatch: invalid reads, illegal-address reset
// - Ready break only after eight bytes; after a pin reset while unlocked the code sends it without them
// - Set bit 6 at RAM 80 on match
// - Mass erase makes stored bytes blank
// - Wired-OR pin, only pull low
module mon_port #(
  parameter logic [15:0] FLASH_BASE = 16'h8000
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic ext_rst_in,
  input wire logic mon_entry_in,
  input wire logic vec_blank_in,
  input wire logic int_osc_in,
  input wire logic comm_in,
  output logic comm_out,
  output logic comm_oe_n_out,
  input wire logic [15:0] vec_fetch_addr_in,
  output logic [15:0] vec_addr_out,
  input wire logic [63:0] stored_sec_in,
  input wire logic mass_erase_in,
  input wire logic [15:0] sp_in,
  input wire logic [7:0] mem_rdata_in,
  output logic [15:0] mem_addr_out,
  output logic [7:0] mem_wdata_out,
  output logic mem_wr_out,
  output logic mem_rd_out,
  output logic run_out,
  input wire logic flash_exec_in,
  output logic illegal_rst_out,
  output logic monitor_out,
  output logic flash_unlock_out
);
  typedef enum logic [3:0] {
    ST_SEC = 4'b0000,
    ST_OPC = 4'b0001,
    ST_OPR = 4'b0010,
    ST_ECHO = 4'b0011,
    ST_DELAY = 4'b0100,
    ST_EXEC = 4'b0101,
    ST_RD = 4'b0110,
    ST_SEND = 4'b0111,
    ST_BRK_GO = 4'b1000,
    ST_BRK = 4'b1001
  } mon_st_t;

  mon_st_t st_q;
  logic monitor_q;
  logic blank_entry_q;
  logic entry_done_q;
  logic unlocked_q;
  logic erased_q;
  logic sec_match_q;
  logic [2:0] sec_idx_q;
  logic [7:0] opc_q;
  logic [1:0] opr_idx_q;
  logic [15:0] addr_q;
  logic [7:0] wdata_q;
  logic [15:0] data_q;
  logic [1:0] send_left_q;
  logic [8:0] cyc_q;
  logic [3:0] dbits_q;
  logic tx_start_q;
  logic tx_brk_q;
  logic [7:0] tx_data_q;
  logic [8:0] bit_cyc;
  logic [7:0] rx_byte;
  logic rx_valid;
  logic rx_break;
  logic tx_low;
  logic tx_busy;
  logic tx_done;
  logic tx_free;

  function automatic logic [1:0] opr_count(input logic [7:0] opc);
    unique case (opc)
      mon_pkg::OPC_READ: opr_count = 2'd2;
      mon_pkg::OPC_WRITE: opr_count = 2'd3;
      mon_pkg::OPC_INDEXED_WRITE_CMD: opr_count = 2'd1;
      default: opr_count = 2'd0;
    endcase
  endfunction : opr_count

  function automatic logic [15:0] next_addr(input logic [15:0] a);
    next_addr = a + 16'h0001;
  endfunction : next_addr

  function automatic logic is_known(input logic [7:0] opc);
    is_known = (opc == mon_pkg::OPC_READ) || (opc == mon_pkg::OPC_WRITE) ||
               (opc == mon_pkg::OPC_INDEXED_READ_CMD) || (opc == mon_pkg::OPC_INDEXED_WRITE_CMD) ||
               (opc == mon_pkg::OPC_STACK_POINTER_READ_CMD) || (opc == mon_pkg::OPC_RUN);
  endfunction : is_known

  // One rate for both directions
  assign bit_cyc = int_osc_in ? mon_pkg::BIT_CYC_INT : mon_pkg::BIT_CYC_EXT;
  assign tx_free = !tx_busy && !tx_start_q;

  // Receiver is blind while transmitting and until our last low bit has left the pin;
  // the registered pin lags the transmitter by a cycle, which would look like a start bit
  mon_rx u_rx (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .en_in(!tx_busy && comm_oe_n_out),
    .bit_cyc_in(bit_cyc),
    .line_in(comm_in),
    .byte_out(rx_byte),
    .byte_valid_out(rx_valid),
    .break_out(rx_break)
  );

  mon_tx u_tx (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .bit_cyc_in(bit_cyc),
    .start_in(tx_start_q),
    .brk_in(tx_brk_q),
    .data_in(tx_data_q),
    .low_out(tx_low),
    .busy_out(tx_busy),
    .done_out(tx_done)
  );

  // Mode latch: sys_rst_in is the power-on reset
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      monitor_q <= 1'b0;
      blank_entry_q <= 1'b0;
      entry_done_q <= 1'b0;
    end else if (!entry_done_q) begin
      entry_done_q <= 1'b1;
      monitor_q <= mon_entry_in || vec_blank_in;
      blank_entry_q <= vec_blank_in;
    end else if (ext_rst_in && !blank_entry_q) begin
      monitor_q <= mon_entry_in;
    end
  end

  // Security state survives every reset but power-on
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      unlocked_q <= 1'b0;
      erased_q <= 1'b0;
    end else begin
      if (mass_erase_in) begin
        erased_q <= 1'b1;
      end
      if (st_q == ST_SEC && rx_valid && sec_idx_q == mon_pkg::SEC_LAST &&
          sec_match_q && rx_byte == (erased_q ? mon_pkg::BLANK_BYTE :
                                     stored_sec_in[{sec_idx_q, 3'b000} +: 8])) begin
        unlocked_q <= 1'b1;
      end
    end
  end

  // Vector page remap
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      vec_addr_out <= 16'h0000;
    end else if (monitor_q && vec_fetch_addr_in[15:8] == mon_pkg::USER_VEC_PAGE &&
                 vec_fetch_addr_in[7:0] >= mon_pkg::VEC_LOW_FIRST) begin
      vec_addr_out <= {mon_pkg::MON_VEC_PAGE, vec_fetch_addr_in[7:0]};
    end else begin
      vec_addr_out <= vec_fetch_addr_in;
    end
  end

  // Pin and status outputs
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      comm_out <= 1'b0;
      comm_oe_n_out <= 1'b1;
      illegal_rst_out <= 1'b0;
      monitor_out <= 1'b0;
      flash_unlock_out <= 1'b0;
    end else begin
      comm_out <= 1'b0;
      comm_oe_n_out <= !tx_low;
      illegal_rst_out <= flash_exec_in && !unlocked_q;
      monitor_out <= monitor_q;
      flash_unlock_out <= unlocked_q;
    end
  end

  // Command engine
  always_ff @(posedge clk_in) begin
    tx_start_q <= 1'b0;
    mem_wr_out <= 1'b0;
    mem_rd_out <= 1'b0;
    run_out <= 1'b0;
    if (sys_rst_in) begin
      st_q <= ST_SEC;
      sec_idx_q <= 3'h0;
      sec_match_q <= 1'b1;
      opc_q <= 8'h00;
      opr_idx_q <= 2'd0;
      addr_q <= 16'h0000;
      wdata_q <= 8'h00;
      data_q <= 16'h0000;
      send_left_q <= 2'd0;
      cyc_q <= 9'h000;
      dbits_q <= 4'h0;
      tx_brk_q <= 1'b0;
      tx_data_q <= 8'h00;
      mem_addr_out <= 16'h0000;
      mem_wdata_out <= 8'h00;
    end else if (ext_rst_in) begin
      // Code entry is asked for again after this kind of reset only while still locked
      st_q <= unlocked_q ? ST_BRK_GO : ST_SEC;
      sec_idx_q <= 3'h0;
      sec_match_q <= 1'b1;
    end else if (rx_break && st_q != ST_SEC) begin
      st_q <= ST_BRK_GO;
    end else begin
      if (rx_valid) begin
        tx_start_q <= 1'b1;
        tx_brk_q <= 1'b0;
        tx_data_q <= rx_byte;
      end
      unique case (st_q)
        ST_SEC: begin
          if (rx_valid) begin
            sec_idx_q <= sec_idx_q + 3'h1;
            if (rx_byte != (erased_q ? mon_pkg::BLANK_BYTE :
                            stored_sec_in[{sec_idx_q, 3'b000} +: 8])) begin
              sec_match_q <= 1'b0;
            end
            if (sec_idx_q == mon_pkg::SEC_LAST) begin
              st_q <= ST_BRK_GO;
              if (sec_match_q && rx_byte == (erased_q ? mon_pkg::BLANK_BYTE :
                                             stored_sec_in[{sec_idx_q, 3'b000} +: 8])) begin
                mem_wr_out <= 1'b1;
                mem_addr_out <= mon_pkg::SEC_FLAG_ADDR;
                mem_wdata_out <= mon_pkg::SEC_FLAG_VAL;
              end
            end
          end
        end
        ST_OPC: begin
          if (rx_valid) begin
            opc_q <= rx_byte;
            opr_idx_q <= 2'd0;
            if (!is_known(rx_byte)) begin
              st_q <= ST_OPC;
            end else if (opr_count(rx_byte) == 2'd0) begin
              st_q <= ST_ECHO;
            end else begin
              st_q <= ST_OPR;
            end
          end
        end
        ST_OPR: begin
          if (rx_valid) begin
            opr_idx_q <= opr_idx_q + 2'd1;
            if (opc_q == mon_pkg::OPC_INDEXED_WRITE_CMD || opr_idx_q == 2'd2) begin
              wdata_q <= rx_byte;
            end else if (opr_idx_q == 2'd0) begin
              addr_q[15:8] <= rx_byte;
            end else begin
              addr_q[7:0] <= rx_byte;
            end
            if (opr_idx_q + 2'd1 == opr_count(opc_q)) begin
              st_q <= ST_ECHO;
            end
          end
        end
        ST_ECHO: begin
          if (tx_done) begin
            st_q <= ST_DELAY;
            cyc_q <= 9'h000;
            dbits_q <= 4'h0;
          end
        end
        ST_DELAY: begin
          // Host may still send a break here to drop the command
          if (cyc_q == bit_cyc - 9'h001) begin
            cyc_q <= 9'h000;
            dbits_q <= dbits_q + 4'h1;
            if (dbits_q == mon_pkg::CMD_DELAY_BITS - 4'h1) begin
              st_q <= ST_EXEC;
            end
          end else begin
            cyc_q <= cyc_q + 9'h001;
          end
        end
        ST_EXEC: begin
          st_q <= ST_OPC;
          unique case (opc_q)
            mon_pkg::OPC_READ: begin
              mem_rd_out <= 1'b1;
              mem_addr_out <= addr_q;
              st_q <= ST_RD;
            end
            mon_pkg::OPC_WRITE: begin
              mem_wr_out <= 1'b1;
              mem_addr_out <= addr_q;
              mem_wdata_out <= wdata_q;
            end
            mon_pkg::OPC_INDEXED_READ_CMD: begin
              addr_q <= next_addr(addr_q);
              mem_rd_out <= 1'b1;
              mem_addr_out <= next_addr(addr_q);
              st_q <= ST_RD;
            end
            mon_pkg::OPC_INDEXED_WRITE_CMD: begin
              addr_q <= next_addr(addr_q);
              mem_wr_out <= 1'b1;
              mem_addr_out <= next_addr(addr_q);
              mem_wdata_out <= wdata_q;
            end
            mon_pkg::OPC_STACK_POINTER_READ_CMD: begin
              data_q <= sp_in + mon_pkg::SP_RET_OFS;
              send_left_q <= 2'd2;
              st_q <= ST_SEND;
            end
            default: begin
              run_out <= 1'b1;
            end
          endcase
        end
        ST_RD: begin
          // Flash bytes read back invalid while locked
          if (!unlocked_q && mem_addr_out >= FLASH_BASE) begin
            data_q <= {mon_pkg::INVALID_BYTE, 8'h00};
          end else begin
            data_q <= {mem_rdata_in, 8'h00};
          end
          send_left_q <= 2'd1;
          st_q <= ST_SEND;
        end
        ST_SEND: begin
          if (tx_free) begin
            if (send_left_q != 2'd0) begin
              tx_start_q <= 1'b1;
              tx_brk_q <= 1'b0;
              tx_data_q <= data_q[15:8];
              data_q <= {data_q[7:0], 8'h00};
              send_left_q <= send_left_q - 2'd1;
            end else begin
              st_q <= ST_OPC;
            end
          end
        end
        ST_BRK_GO: begin
          if (tx_free && !rx_valid) begin
            tx_start_q <= 1'b1;
            tx_brk_q <= 1'b1;
            st_q <= ST_BRK;
          end
        end
        ST_BRK: begin
          if (tx_done) begin
            st_q <= ST_OPC;
          end
        end
        default: st_q <= ST_OPC;
      endcase
    end
  end
endmodule : mon_port

// ===== design/mon_rx.sv
`timescale 1ns/1ps
module mon_rx (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic en_in,
  input wire logic [8:0] bit_cyc_in,
  input wire logic line_in,
  output logic [7:0] byte_out,
  output logic byte_valid_out,
  output logic break_out
);
  typedef enum logic [1:0] {RX_IDLE = 2'b00, RX_SHIFT = 2'b01, RX_HIGH = 2'b10} rx_st_t;
  rx_st_t st_q;
  logic [8:0] cnt_q;
  logic [3:0] bits_q;
  logic [8:0] sh_q;

  always_ff @(posedge clk_in) begin
    byte_valid_out <= 1'b0;
    break_out <= 1'b0;
    if (sys_rst_in) begin
      st_q <= RX_IDLE;
      cnt_q <= 9'h000;
      bits_q <= 4'h0;
      sh_q <= 9'h000;
      byte_out <= 8'h00;
    end else begin
      unique case (st_q)
        RX_IDLE: begin
          if (en_in && !line_in) begin
            cnt_q <= bit_cyc_in >> 1;
            bits_q <= 4'h0;
            st_q <= RX_SHIFT;
          end
        end
        RX_SHIFT: begin
          if (cnt_q != 9'h000) begin
            cnt_q <= cnt_q - 9'h001;
          end else begin
            cnt_q <= bit_cyc_in - 9'h001;
            bits_q <= bits_q + 4'h1;
            sh_q <= {line_in, sh_q[8:1]};
            if (bits_q == mon_pkg::FRAME_BITS - 4'h1) begin
              st_q <= RX_HIGH;
              // Start, eight data and stop all low is a break
              if (line_in) begin
                byte_valid_out <= 1'b1;
                byte_out <= sh_q[8:1];
              end else if (sh_q[8:1] == 8'h00) begin
                break_out <= 1'b1;
              end
            end
          end
        end
        RX_HIGH: begin
          // Waiting for release keeps a long break from framing twice
          if (line_in) begin
            st_q <= RX_IDLE;
          end
        end
        default: st_q <= RX_IDLE;
      endcase
    end
  end
endmodule : mon_rx

// ===== design/mon_tx.sv
`timescale 1ns/1ps
module mon_tx (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic [8:0] bit_cyc_in,
  input wire logic start_in,
  input wire logic brk_in,
  input wire logic [7:0] data_in,
  output logic low_out,
  output logic busy_out,
  output logic done_out
);
  logic [8:0] cnt_q;
  logic [3:0] bitn_q;
  logic [9:0] sh_q;

  always_ff @(posedge clk_in) begin
    done_out <= 1'b0;
    if (sys_rst_in) begin
      cnt_q <= 9'h000;
      bitn_q <= 4'h0;
      sh_q <= 10'h3ff;
      busy_out <= 1'b0;
      low_out <= 1'b0;
    end else if (!busy_out) begin
      if (start_in) begin
        busy_out <= 1'b1;
        cnt_q <= bit_cyc_in - 9'h001;
        bitn_q <= 4'h0;
        sh_q <= brk_in ? 10'h000 : {1'b1, data_in, 1'b0};
      end
    end else if (cnt_q != 9'h000) begin
      cnt_q <= cnt_q - 9'h001;
    end else begin
      cnt_q <= bit_cyc_in - 9'h001;
      bitn_q <= bitn_q + 4'h1;
      // Two released bit times precede every frame
      if (bitn_q >= mon_pkg::GAP_BITS - 4'h1) begin
        low_out <= !sh_q[0];
        sh_q <= {1'b1, sh_q[9:1]};
      end
      if (bitn_q == mon_pkg::GAP_BITS + mon_pkg::FRAME_BITS - 4'h1) begin
        low_out <= 1'b0;
        busy_out <= 1'b0;
        done_out <= 1'b1;
      end
    end
  end
endmodule : mon_tx

// ===== test/host_model.sv
`timescale 1ns/1ps
module host_model #(
  parameter int B = 206
) (
  input wire logic clk_in,
  input wire logic line_in,
  output logic pull_out
);
  initial pull_out = 1'b0;
  // Only pulls low or lets go; the pull-up makes the high level
  task automatic put(input logic [9:0] f);
    repeat (B + B / 2) @(posedge clk_in);
    #1;
    for (int i = 0; i < 10; i++) begin
      pull_out = ~f[i];
      repeat (B) @(posedge clk_in);
      #1;
    end
    pull_out = 1'b0;
  endtask : put
  task automatic send_byte(input logic [7:0] b);
    put({1'b1, b, 1'b0});
  endtask : send_byte
  // Returns at the middle of the last bit, or once a break is let go, so a back-to-back frame is not missed
  task automatic recv(output logic [7:0] d, output logic brk, output int gap);
    logic [9:0] f;
    gap = 0;
    while (line_in === 1'b1 && gap < 20 * B) begin
      @(posedge clk_in);
      gap++;
    end
    repeat (B / 2) @(posedge clk_in);
    for (int i = 0; i < 10; i++) begin
      f[i] = line_in;
      if (i < 9) repeat (B) @(posedge clk_in);
    end
    d = f[8:1];
    brk = (f === 10'h000);
    for (int k = 0; k < 2 * B && line_in !== 1'b1; k++) @(posedge clk_in);
  endtask : recv
endmodule : host_model

// ===== test/mon_port_monitor.sv
`timescale 1ns/1ps
module mon_port_monitor (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic ext_rst_in,
  input wire logic vec_blank_in,
  input wire logic int_osc_in,
  input wire logic comm_out,
  input wire logic comm_oe_n_out,
  input wire logic [15:0] vec_fetch_addr_in,
  input wire logic [15:0] vec_addr_out,
  input wire logic mem_rd_out,
  input wire logic run_out,
  input wire logic flash_exec_in,
  input wire logic illegal_rst_out,
  input wire logic monitor_out,
  input wire logic flash_unlock_out
);
  logic [11:0] lo_cnt_q;
  int bit_c;
  assign bit_c = int_osc_in ? 206 : 256;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  // Length of the current pull-low run, judged when the pin is let go
  always_ff @(posedge clk_in) begin
    if (sys_rst_in || comm_oe_n_out) begin
      lo_cnt_q <= 12'h000;
    end else begin
      lo_cnt_q <= lo_cnt_q + 12'h001;
    end
  end
  AST_VEC_MAP: assert property (
    (monitor_out && vec_fetch_addr_in[15:2] == 14'h3fff) |=>
    vec_addr_out == {8'hfe, $past(vec_fetch_addr_in[7:0])})
    else $error("Monitor vector not on page fe");
  AST_BIT_TIME: assert property (
    $rose(comm_oe_n_out) |-> (int'(lo_cnt_q) % bit_c) == 0)
    else $error("Low run not whole bit times");
  AST_BREAK_MAX: assert property (
    int'(lo_cnt_q) <= 10 * bit_c)
    else $error("Low run longer than ten bits");
  AST_COMM_ZERO: assert property (
    comm_out == 1'b0)
    else $error("Pin driven high");
  AST_RD_GAP: assert property (
    mem_rd_out |=> comm_oe_n_out [*8])
    else $error("No gap after memory read");
  AST_ILLEGAL: assert property (
    1'b1 |-> illegal_rst_out == ($past(flash_exec_in) && !flash_unlock_out))
    else $error("Illegal reset mismatch");
  AST_RUN_PULSE: assert property (
    run_out |=> !run_out)
    else $error("Run strobe longer than one cycle");
  AST_MON_KEEP: assert property (
    (vec_blank_in && monitor_out && ext_rst_in) |=> monitor_out)
    else $error("Monitor left on pin reset");
  AST_UNLOCK_KEEP: assert property (
    flash_unlock_out |=> flash_unlock_out)
    else $error("Unlock lost without power-on");
endmodule : mon_port_monitor

bind mon_port mon_port_monitor u_mon (
  .clk_in(clk_in),
  .sys_rst_in(sys_rst_in),
  .ext_rst_in(ext_rst_in),
  .vec_blank_in(vec_blank_in),
  .int_osc_in(int_osc_in),
  .comm_out(comm_out),
  .comm_oe_n_out(comm_oe_n_out),
  .vec_fetch_addr_in(vec_fetch_addr_in),
  .vec_addr_out(vec_addr_out),
  .mem_rd_out(mem_rd_out),
  .run_out(run_out),
  .flash_exec_in(flash_exec_in),
  .illegal_rst_out(illegal_rst_out),
  .monitor_out(monitor_out),
  .flash_unlock_out(flash_unlock_out)
);

// ===== test/mon_port_tb.sv
`timescale 1ns/1ps
module mon_port_tb;
  localparam int B = 206;
  localparam int LIMIT = 96000;
  localparam logic [63:0] SEC = 64'h8e7d6c5b4a392817;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic ext_rst_in = 1'b0;
  logic flash_exec_in = 1'b0;
  logic [15:0] vec_fetch_addr_in = 16'h0000;
  logic [7:0] mem_rdata_in = 8'h00;
  logic [7:0] mem [0:65535];
  logic comm_out, comm_oe_n_out, mem_wr_out, mem_rd_out, run_out;
  logic illegal_rst_out, monitor_out, flash_unlock_out;
  logic [15:0] vec_addr_out, mem_addr_out;
  logic [7:0] mem_wdata_out;
  wire logic host_pull;
  wire logic comm_line;
  int n_mismatch = 0;
  int n_compared = 0;
  int cyc = 0;
  assign comm_line = (comm_oe_n_out ? 1'b1 : comm_out) & ~host_pull;
  always #5 clk_in = ~clk_in;
  mon_port DUT (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .ext_rst_in(ext_rst_in),
    .mon_entry_in(1'b0), .vec_blank_in(1'b1), .int_osc_in(1'b1),
    .comm_in(comm_line), .comm_out(comm_out), .comm_oe_n_out(comm_oe_n_out),
    .vec_fetch_addr_in(vec_fetch_addr_in), .vec_addr_out(vec_addr_out),
    .stored_sec_in(SEC), .mass_erase_in(1'b0), .sp_in(16'h01ef),
    .mem_rdata_in(mem_rdata_in), .mem_addr_out(mem_addr_out),
    .mem_wdata_out(mem_wdata_out), .mem_wr_out(mem_wr_out), .mem_rd_out(mem_rd_out),
    .run_out(run_out), .flash_exec_in(flash_exec_in),
    .illegal_rst_out(illegal_rst_out), .monitor_out(monitor_out),
    .flash_unlock_out(flash_unlock_out)
  );
  host_model #(.B(B)) u_host (.clk_in(clk_in), .line_in(comm_line), .pull_out(host_pull));
  // Memory answers within the read strobe's own cycle, as the engine samples it there
  always @(posedge clk_in) begin
    if (mem_wr_out) mem[mem_addr_out] <= mem_wdata_out;
  end
  always @(negedge clk_in) begin
    if (mem_rd_out) mem_rdata_in <= mem[mem_addr_out];
  end
  task automatic tally_and_finish;
    $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : tally_and_finish
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == LIMIT) begin
      n_mismatch++;
      $display("[ERR] %0t run too long", $time);
      tally_and_finish();
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t %s: got %h want %h", $time, what, seen, exp);
    end
  endtask : check
  task automatic xfer(input logic [7:0] b);
    logic [7:0] d;
    logic brk;
    int gap;
    u_host.send_byte(b);
    u_host.recv(d, brk, gap);
    check({8'h00, d}, {8'h00, b}, "echo");
    check({15'h0000, brk}, 16'h0000, "echo is break");
    check(16'(gap >= B && gap <= 3 * B), 16'h0001, "echo gap");
  endtask : xfer
  task automatic rdata(input logic [7:0] e, input int lo, input int hi);
    logic [7:0] d;
    logic brk;
    int gap;
    u_host.recv(d, brk, gap);
    check({8'h00, d}, {8'h00, e}, "read data");
    check(16'(gap >= lo && gap <= hi), 16'h0001, "read delay");
  endtask : rdata
  task automatic t_locked;
    check({15'h0000, monitor_out}, 16'h0001, "monitor entry");
    @(posedge clk_in);
    #1 flash_exec_in = 1'b1;
    @(posedge clk_in);
    #1 check({15'h0000, illegal_rst_out}, 16'h0001, "illegal reset");
    flash_exec_in = 1'b0;
    $display("test locked done");
  endtask : t_locked
  task automatic t_security;
    logic [7:0] d;
    logic brk;
    int gap;
    for (int i = 0; i < 8; i++) xfer(SEC[8*i +: 8]);
    u_host.recv(d, brk, gap);
    check({15'h0000, brk}, 16'h0001, "ready break");
    check({15'h0000, flash_unlock_out}, 16'h0001, "unlock");
    check({8'h00, mem[16'h0080]}, 16'h0040, "unlock flag");
    $display("test security done");
  endtask : t_security
  task automatic t_vectors;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_in);
      #1 vec_fetch_addr_in = 16'hfffc + 16'(i);
      @(posedge clk_in);
      #1 check(vec_addr_out, 16'hfefc + 16'(i), "vector");
    end
    $display("test vectors done");
  endtask : t_vectors
  task automatic t_read;
    mem[16'h1234] = 8'h5a;
    xfer(mon_pkg::OPC_READ);
    xfer(8'h12);
    xfer(8'h34);
    rdata(8'h5a, 11 * B, 15 * B);
    $display("test read done");
  endtask : t_read
  task automatic t_indexed_write_cmd;
    xfer(mon_pkg::OPC_INDEXED_WRITE_CMD);
    xfer(8'ha5);
    repeat (13 * B) @(posedge clk_in);
    check({8'h00, mem[16'h1235]}, 16'h00a5, "indexed write");
    $display("test indexed_write_cmd done");
  endtask : t_indexed_write_cmd
  task automatic t_stack_pointer_read_cmd;
    xfer(mon_pkg::OPC_STACK_POINTER_READ_CMD);
    rdata(8'h01, 11 * B, 15 * B);
    rdata(8'hf0, 0, 3 * B);
    $display("test stack_pointer_read_cmd done");
  endtask : t_stack_pointer_read_cmd
  task automatic t_ext_reset;
    logic [7:0] d;
    logic brk;
    int gap;
    @(posedge clk_in);
    #1 ext_rst_in = 1'b1;
    repeat (4) @(posedge clk_in);
    #1 ext_rst_in = 1'b0;
    check({15'h0000, monitor_out}, 16'h0001, "monitor kept");
    u_host.recv(d, brk, gap);
    check({15'h0000, brk}, 16'h0001, "break without code");
    check({15'h0000, flash_unlock_out}, 16'h0001, "unlock kept");
    $display("test ext reset done");
  endtask : t_ext_reset
  initial begin
    repeat (8) @(posedge clk_in);
    #1 sys_rst_in = 1'b0;
    repeat (3) @(posedge clk_in);
    #1;
    t_locked();
    t_security();
    t_vectors();
    t_read();
    t_indexed_write_cmd();
    t_stack_pointer_read_cmd();
    t_ext_reset();
    tally_and_finish();
  end
endmodule : mon_port_tb
